// [rtl/cap_checker.sv]
// command/address parity checker with alert and error log
// assumes all inputs synchronous to clk; one frame per cs-qualified cycle
`timescale 1ns/1ps
`include "cap_consts.svh"
module cap_checker
    import cap_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // command/address bus, cs qualified
    input  wire logic        cmd_sel,
    input  wire logic        cmd_act_n,
    input  wire logic        cmd_ras_n,
    input  wire logic        cmd_cas_n,
    input  wire logic        cmd_we_n,
    input  wire logic [1:0]  cmd_bg,
    input  wire logic [1:0]  cmd_ba,
    input  wire logic [13:0] cmd_addr,
    input  wire logic        cmd_par,
    // parity_mode_register write port
    input  wire logic        mr_wr,
    input  wire logic [9:0]  mr_wdata,
    // command release towards the core
    output logic             exec_vld_q,
    output cap_frame_t       exec_frame_q,
    output logic             prech_all_q,
    // alert and status
    output logic             alert_n_q,
    output logic             par_err_stat_q,
    output logic             persist_q,
    output logic [2:0]       pl_code_q,
    output logic [3:0]       pl_cycles_q,
    // readout_error_page
    output cap_frame_t       err_log_q,
    output logic             err_log_par_q,
    output logic             err_multi_q
);
    cap_state_t state_q;
    logic [7:0] cnt_q;
    logic [7:0] pw_q;
    cap_frame_t in_frame;
    logic       dl_vld;
    cap_frame_t dl_frame;
    logic       dl_err;
    logic       checking;
    logic       err_hit;
    logic       blocked;
    logic [3:0] lat_d;
    logic       prech_seen_q;

    // unused stacking address bits tie to zero
    assign in_frame = {2'h0, cmd_act_n, cmd_ras_n, cmd_cas_n, cmd_we_n,
                       cmd_bg, cmd_ba, cmd_addr};

    cap_delay_line u_dl
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_vld    (cmd_sel),
        .in_frame  (in_frame),
        .in_par    (cmd_par),
        .tap       (pl_cycles_q),
        .out_vld   (dl_vld),
        .out_frame (dl_frame),
        .out_err   (dl_err)
    );

    always_comb
    begin
        unique case (mr_wdata[`CAP_MR_PL_MSB:`CAP_MR_PL_LSB])
            `CAP_PL_4: lat_d = `CAP_LAT_4;
            `CAP_PL_5: lat_d = `CAP_LAT_5;
            `CAP_PL_6: lat_d = `CAP_LAT_6;
            `CAP_PL_8: lat_d = `CAP_LAT_8;
            default:   lat_d = 4'h0; // off and reserved codes
        endcase
    end

    // mode register: latency and persist written, status only cleared
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pl_code_q   <= `CAP_MR_RESET;
            pl_cycles_q <= 4'h0;
            persist_q   <= 1'b0;
        end
        else if (mr_wr)
        begin
            pl_code_q   <= mr_wdata[`CAP_MR_PL_MSB:`CAP_MR_PL_LSB];
            pl_cycles_q <= lat_d;
            persist_q   <= mr_wdata[`CAP_MR_PERS_BIT];
        end
    end

    assign blocked  = (state_q != CAP_IDLE);
    assign checking = (pl_cycles_q != 4'h0) && !blocked
                      && (!par_err_stat_q || persist_q);
    assign err_hit  = dl_vld && dl_err && checking;

    // status: set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            par_err_stat_q <= 1'b0;
        else if (err_hit)
            par_err_stat_q <= 1'b1;
        else if (mr_wr && !mr_wdata[`CAP_MR_STAT_BIT])
            par_err_stat_q <= 1'b0;
    end

    // error log keeps the first frame; later errors mark it stale
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            err_log_q     <= '0;
            err_log_par_q <= 1'b0;
            err_multi_q   <= 1'b0;
        end
        else if (err_hit && !par_err_stat_q)
        begin
            err_log_q     <= dl_frame;
            err_log_par_q <= ~^dl_frame;
            err_multi_q   <= 1'b0;
        end
        else if (err_hit)
            err_multi_q   <= 1'b1;
        else if (mr_wr && !mr_wdata[`CAP_MR_STAT_BIT])
            err_multi_q   <= 1'b0;
    end

    // release delayed commands; drop the erroneous one and block
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            exec_vld_q   <= 1'b0;
            exec_frame_q <= '0;
        end
        else
        begin
            exec_vld_q   <= dl_vld && !err_hit && !blocked;
            exec_frame_q <= dl_frame;
        end
    end

    // alert sequence: drain, tras wait, precharge, pulse
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q     <= CAP_IDLE;
            cnt_q       <= 8'h0;
            pw_q        <= 8'h0;
            alert_n_q   <= 1'b1;
            prech_all_q <= 1'b0;
        end
        else
        begin
            prech_all_q <= 1'b0;
            if (!alert_n_q)
                pw_q <= pw_q + 8'h1;
            unique case (state_q)
                CAP_IDLE:
                begin
                    if (err_hit)
                    begin
                        state_q   <= CAP_DRAIN;
                        alert_n_q <= 1'b0;
                        pw_q      <= 8'h0;
                        cnt_q     <= 8'h0;
                    end
                end
                CAP_DRAIN:
                begin
                    cnt_q <= cnt_q + 8'h1;
                    if (cnt_q == 8'(`CAP_TRAS_CYC - 1))
                    begin
                        state_q     <= CAP_PRECH;
                        prech_all_q <= 1'b1;
                    end
                end
                CAP_PRECH:
                    state_q <= CAP_PULSE;
                CAP_PULSE:
                begin
                    if (pw_q >= 8'(`CAP_PW_MIN_CYC - 1))
                    begin
                        alert_n_q <= 1'b1;
                        state_q   <= CAP_HOLD;
                        cnt_q     <= 8'h0;
                    end
                end
                CAP_HOLD:
                begin
                    cnt_q <= cnt_q + 8'h1;
                    if (cnt_q == 8'(`CAP_PW_MAX_CYC - `CAP_PW_MIN_CYC))
                        state_q <= CAP_IDLE;
                end
                default:
                    state_q <= CAP_IDLE;
            endcase
        end
    end

    // remembers a precharge-all inside the current alert pulse
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            prech_seen_q <= 1'b0;
        else if (alert_n_q)
            prech_seen_q <= 1'b0;
        else if (prech_all_q)
            prech_seen_q <= 1'b1;
    end

    AST_ALERT_ON: assert property (
        @(posedge clk) disable iff (sys_rst)
        err_hit |=> !alert_n_q && par_err_stat_q)
        else $error("alert not asserted after error");
    AST_DROP: assert property (
        @(posedge clk) disable iff (sys_rst)
        err_hit |=> !exec_vld_q)
        else $error("erroneous command executed");
    AST_STAT_BEFORE_REL: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(alert_n_q) |-> par_err_stat_q || $past(mr_wr))
        else $error("alert released with status clear");
    AST_PW_MIN: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(alert_n_q) |-> $past(pw_q) >= 8'(`CAP_PW_MIN_CYC - 1))
        else $error("alert pulse too short");
    AST_PRECH_BEFORE_REL: assert property (
        @(posedge clk) disable iff (sys_rst)
        prech_all_q |-> !alert_n_q ##1 !alert_n_q)
        else $error("alert released before precharge");
    AST_BLOCK: assert property (
        @(posedge clk) disable iff (sys_rst)
        !alert_n_q |=> !exec_vld_q)
        else $error("command executed during alert");
    AST_NOCHECK: assert property (
        @(posedge clk) disable iff (sys_rst)
        par_err_stat_q && !persist_q |-> !err_hit)
        else $error("checking while status set");
    AST_OFF: assert property (
        @(posedge clk) disable iff (sys_rst)
        pl_code_q == `CAP_PL_OFF |-> pl_cycles_q == 4'h0 && !err_hit)
        else $error("checking with latency disabled");
    AST_MULTI: assert property (
        @(posedge clk) disable iff (sys_rst)
        err_hit && par_err_stat_q |=> err_multi_q)
        else $error("second error not flagged");
    AST_REL_AFTER_PRECH: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(alert_n_q) |-> $past(prech_seen_q))
        else $error("alert released without precharge-all");
    AST_PW_MAX: assert property (
        @(posedge clk) disable iff (sys_rst)
        !alert_n_q |-> pw_q < 8'(`CAP_PW_MAX_CYC))
        else $error("alert pulse too long");
    AST_LOG_KEEP: assert property (
        @(posedge clk) disable iff (sys_rst)
        err_hit && par_err_stat_q |=> $stable(err_log_q))
        else $error("first logged frame overwritten");
    AST_STAT_ONE: assert property (
        @(posedge clk) disable iff (sys_rst)
        mr_wr && mr_wdata[`CAP_MR_STAT_BIT] && !par_err_stat_q && !err_hit
        |=> !par_err_stat_q)
        else $error("status set by a write of one");
    AST_RESERVED: assert property (
        @(posedge clk) disable iff (sys_rst)
        pl_code_q > `CAP_PL_8 |-> pl_cycles_q == 4'h0)
        else $error("reserved latency code enabled checking");
    AST_LAT8: assert property (
        @(posedge clk) disable iff (sys_rst)
        pl_code_q == `CAP_PL_8 |-> pl_cycles_q == `CAP_LAT_8)
        else $error("latency code for eight clocks mapped wrongly");
    AST_PERSIST: assert property (
        @(posedge clk) disable iff (sys_rst)
        persist_q && !blocked && pl_cycles_q != 4'h0 && dl_vld && dl_err
        |-> err_hit)
        else $error("persistent mode missed a parity error");
    AST_UNCHECKED: assert property (
        @(posedge clk) disable iff (sys_rst)
        par_err_stat_q && !persist_q && !blocked && dl_vld |=> exec_vld_q)
        else $error("unchecked command not executed");
endmodule

// [pkg/cap_consts.svh]
// constants for the command/address parity checker
// included by the package and the design files; definitions only
`ifndef CAP_CONSTS_SVH
`define CAP_CONSTS_SVH
`define CAP_PL_OFF       3'h0
`define CAP_PL_4         3'h1
`define CAP_PL_5         3'h2
`define CAP_PL_6         3'h3
`define CAP_PL_8         3'h4
`define CAP_LAT_4        4'h4
`define CAP_LAT_5        4'h5
`define CAP_LAT_6        4'h6
`define CAP_LAT_8        4'h8
`define CAP_MR_PL_LSB    0
`define CAP_MR_PL_MSB    2
`define CAP_MR_STAT_BIT  4
`define CAP_MR_PERS_BIT  9
`define CAP_MR_RESET     3'h0
`define CAP_CLK_NS       50
`define CAP_ALERT_ON_NS  500
`define CAP_PW_MIN_NS    1000
`define CAP_PW_MAX_NS    2000
`define CAP_TRAS_NS      400
`define CAP_ALERT_ON_CYC (`CAP_ALERT_ON_NS / `CAP_CLK_NS)
`define CAP_PW_MIN_CYC   ((`CAP_PW_MIN_NS + `CAP_CLK_NS - 1) / `CAP_CLK_NS)
`define CAP_PW_MAX_CYC   (`CAP_PW_MAX_NS / `CAP_CLK_NS)
`define CAP_TRAS_CYC     ((`CAP_TRAS_NS + `CAP_CLK_NS - 1) / `CAP_CLK_NS)
`define CAP_FRAME_W      24
`define CAP_DEPTH        8
`endif

// [pkg/cap_pkg.sv]
// types for the command/address parity checker
// relies on cap_consts.svh for the frame width; state encodings are given here
`include "cap_consts.svh"
package cap_pkg;
    typedef logic [`CAP_FRAME_W-1:0] cap_frame_t;
    typedef enum logic [2:0]
    {
        CAP_IDLE   = 3'b000,
        CAP_DRAIN  = 3'b001,
        CAP_PRECH  = 3'b010,
        CAP_PULSE  = 3'b011,
        CAP_HOLD   = 3'b100
    } cap_state_t;
endpackage

// [rtl/cap_delay_line.sv]
// programmable delay line holding frames for the parity latency
// assumes one clock; tap index selects depth, 0 means bypass
`timescale 1ns/1ps
`include "cap_consts.svh"
module cap_delay_line
    import cap_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // frame in
    input  wire logic       in_vld,
    input  wire cap_frame_t in_frame,
    input  wire logic       in_par,
    input  wire logic [3:0] tap,
    // frame out
    output logic            out_vld,
    output cap_frame_t      out_frame,
    output logic            out_err
);
    logic       vld_q   [`CAP_DEPTH];
    cap_frame_t frame_q [`CAP_DEPTH];
    logic       err_q   [`CAP_DEPTH];

    // parity judged at capture, then carried down the pipeline
    genvar i;
    generate
        for (i = 0; i < `CAP_DEPTH; i++)
        begin : g_stage
            logic       vld_src;
            cap_frame_t frame_src;
            logic       err_src;
            if (i == 0)
            begin : g_head
                assign vld_src   = in_vld;
                assign frame_src = in_frame;
                assign err_src   = ^{in_frame, in_par};
            end
            else
            begin : g_tail
                assign vld_src   = vld_q[i-1];
                assign frame_src = frame_q[i-1];
                assign err_src   = err_q[i-1];
            end
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    vld_q[i]   <= 1'b0;
                    frame_q[i] <= '0;
                    err_q[i]   <= 1'b0;
                end
                else
                begin
                    vld_q[i]   <= vld_src;
                    frame_q[i] <= frame_src;
                    err_q[i]   <= err_src;
                end
            end
        end
    endgenerate

    always_comb
    begin
        if (tap == 4'h0)
        begin
            out_vld   = in_vld;
            out_frame = in_frame;
            out_err   = 1'b0;
        end
        else
        begin
            out_vld   = vld_q[3'(tap - 4'h1)];
            out_frame = frame_q[3'(tap - 4'h1)];
            out_err   = err_q[3'(tap - 4'h1)];
        end
    end
endmodule

// [dv/cap_host_model.sv]
// controller model driving the command/address bus
// assumes the bench calls send and idle; one clock
`timescale 1ns/1ps
module cap_host_model
(
    // clock and alert
    input  wire logic   clk,
    input  wire logic   alert_n,
    // command/address bus
    output logic        sel,
    output logic [21:0] ca,
    output logic        par
);
    initial
    begin
        sel = 1'b0;
        ca  = 22'h0;
        par = 1'b0;
    end
    // one command; bad flips parity on purpose
    task automatic send(input logic [21:0] f, input logic bad);
        @(posedge clk);
        #1;
        sel = alert_n;
        ca  = f;
        par = (^f) ^ bad;
    endtask
    // deselects; the lines keep toggling
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            sel = 1'b0;
            ca  = ~ca;
            par = ~par;
        end
    endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the command/address parity checker
// assumes cap_host_model drives the bus
`timescale 1ns/1ps
`include "cap_consts.svh"
module tb
    import cap_pkg::*;
;
    logic clk, sys_rst, sel, par, mr_wr;
    logic [21:0] ca, last_f;
    logic [9:0] mr_wdata;
    logic exec_vld_q, prech_all_q, alert_n_q, par_err_stat_q;
    logic persist_q, err_log_par_q, err_multi_q;
    logic [2:0] pl_code_q;
    logic [3:0] pl_cycles_q;
    cap_frame_t exec_frame_q, err_log_q;
    int num_errors = 0, num_checks = 0, cyc = 0, pl = 0;
    logic [31:0] seed = 32'hC7645378;
    cap_frame_t exp_f[$];
    int exp_c[$];

    cap_host_model i_host (.clk(clk), .alert_n(alert_n_q),
        .sel(sel), .ca(ca), .par(par));
    cap_checker i_dut (.clk(clk), .sys_rst(sys_rst),
        .cmd_sel(sel), .cmd_act_n(ca[21]), .cmd_ras_n(ca[20]),
        .cmd_cas_n(ca[19]), .cmd_we_n(ca[18]), .cmd_bg(ca[17:16]),
        .cmd_ba(ca[15:14]), .cmd_addr(ca[13:0]), .cmd_par(par),
        .mr_wr(mr_wr), .mr_wdata(mr_wdata),
        .exec_vld_q(exec_vld_q), .exec_frame_q(exec_frame_q),
        .prech_all_q(prech_all_q), .alert_n_q(alert_n_q),
        .par_err_stat_q(par_err_stat_q), .persist_q(persist_q),
        .pl_code_q(pl_code_q), .pl_cycles_q(pl_cycles_q),
        .err_log_q(err_log_q), .err_log_par_q(err_log_par_q),
        .err_multi_q(err_multi_q));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // released commands are matched in order, with their cycle
    always @(negedge clk)
        if (exec_vld_q === 1'b1)
        begin
            if (exp_f.size() == 0)
                chk("unexpected exec", 0, 1);
            else
            begin
                chk("exec frame", exp_f.pop_front(), exec_frame_q);
                chk("exec cycle", exp_c.pop_front(), cyc);
            end
        end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmd(input logic bad, input logic ex);
        seed = lfsr_next(seed);
        last_f = seed[21:0];
        i_host.send(last_f, bad);
        if (ex)
        begin
            exp_f.push_back(cap_frame_t'(last_f));
            exp_c.push_back(cyc + pl + 1);
        end
    endtask
    task automatic mr(input logic [9:0] d);
        @(posedge clk);
        #1;
        mr_wr = 1'b1;
        mr_wdata = d;
        @(posedge clk);
        #1;
        mr_wr = 1'b0;
    endtask
    // latency changes only pass through the disabled code
    task automatic set_pl(input logic [2:0] c, input logic p);
        mr({p, 9'h0});
        mr({p, 6'h0, c});
        pl = (c == 3'h4) ? 8 : (c != 0 && c < 3'h4) ? c + 3 : 0;
        chk("pl cycles", pl, pl_cycles_q);
        chk("pl code", c, pl_code_q);
        chk("persist", p, persist_q);
    endtask
    task automatic err_case(input logic multi);
        int n, pc;
        cmd(1'b0, 1'b1);
        cmd(1'b1, 1'b0);
        i_host.idle(pl + 2);
        chk("alert on", 0, alert_n_q);
        chk("stat set", 1, par_err_stat_q);
        if (multi)
            chk("multi", 1, err_multi_q);
        else
        begin
            chk("log", cap_frame_t'(last_f), err_log_q);
            chk("log par", (^last_f) ^ 1'b1, err_log_par_q);
        end
        n = 0;
        pc = 0;
        while (alert_n_q === 1'b0 && n < 100)
        begin
            i_host.idle(1);
            n++;
            if (prech_all_q === 1'b1)
                pc++;
        end
        chk("pulse min", 1, n + 1 >= `CAP_PW_MIN_CYC);
        chk("pulse max", 1, n <= `CAP_PW_MAX_CYC);
        chk("prech all", 1, pc);
        i_host.idle(4);
        cmd(1'b0, 1'b0);
        i_host.idle(30);
        cmd(1'b0, 1'b1);
        i_host.idle(12);
    endtask

    initial
    begin
        sys_rst = 1'b1;
        mr_wr = 1'b0;
        mr_wdata = 10'h0;
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("alert idle", 1, alert_n_q);
        chk("code reset", 0, pl_code_q);
        // latency codes 0 to 4, reserved code 5 too, back to back
        for (int c = 0; c < 6; c++)
        begin
            set_pl(c[2:0], 1'b0);
            repeat (6) cmd(1'b0, 1'b1);
            i_host.idle(12);
        end
        set_pl(3'h1, 1'b0);
        err_case(1'b0);
        cmd(1'b1, 1'b1);
        i_host.idle(12);
        mr(10'h011);
        chk("stat hold", 1, par_err_stat_q);
        mr(10'h001);
        chk("stat clear", 0, par_err_stat_q);
        mr(10'h011);
        chk("stat one", 0, par_err_stat_q);
        err_case(1'b0);
        set_pl(3'h3, 1'b1);
        err_case(1'b0);
        err_case(1'b1);
        mr(10'h203);
        chk("stat persist clear", 0, par_err_stat_q);
        chk("multi clear", 0, err_multi_q);
        chk("queue empty", 0, exp_f.size());
        finish_test();
    end
    initial
    begin
        #1000000;
        num_errors++;
        finish_test();
    end
endmodule
